// ===== rtl/ssic_pkg.sv
// Constants for the serial port interrupt-control block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
//
// Contract
// (RQ1) Hardware reset and the software reset instruction both clear every control-B bit.
// (RQ2) With bit 23 set, a receive exception request is raised while rx full and overrun are set.
// (RQ3) A status read then a receive data read clears the overrun flag and its request.
// (RQ4) With bit 22 set, a transmit exception request is raised while tx empty and underrun are set.
// (RQ5) A status read then writes to every enabled transmitter's data clears underrun and request.
// (RQ6) In network mode with bit 21 set, a request follows the end of each frame's last slot.
// (RQ7) In network mode with bit 20 set, a request comes at the start of each frame's last slot.
// (RQ8) Both last-slot requests are suppressed while the frame divider field is zero.
// (RQ9) Bit 19 with rx full raises a receive request; reading receive data clears full and it.
// (RQ10) Overrun with the exception enable gives the exception request, above the normal one.
// (RQ11) Bit 18 with tx empty raises a transmit request; clearing the bit masks it.
// (RQ12) Writing enabled transmitters' data or the time slot register clears tx empty.
// (RQ13) Underrun with the exception enable gives the exception request, above the normal one.
// (RQ14) In network mode, clearing then setting a tx enable disables it until the next frame.
// (RQ15) A transmitter so disabled holds its serial output pin in high impedance.
// (RQ16) Software waits for tx empty, writes the flags, then writes transmit data.
// (RQ17) Each request is a level held until its clearing condition or its enable is cleared.

package ssic_pkg;

  localparam logic [7:0]  ADDR_CTL_B    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_RX_DATA  = 8'h08;
  localparam logic [7:0]  ADDR_TX0      = 8'h0C;
  localparam logic [7:0]  ADDR_TX1      = 8'h10;
  localparam logic [7:0]  ADDR_TX2      = 8'h14;
  localparam logic [7:0]  ADDR_TSLOT    = 8'h18;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h1C;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h20;
  localparam logic [7:0]  ADDR_FRAME    = 8'h24;

  localparam int          CTL_W         = 24;
  localparam logic [23:0] CTL_RESET     = 24'h000000;
  localparam int          B_RX_EXC_EN   = 23;
  localparam int          B_TX_EXC_EN   = 22;
  localparam int          B_RX_LAST_EN  = 21;
  localparam int          B_TX_LAST_EN  = 20;
  localparam int          B_RX_EN_IRQ   = 19;
  localparam int          B_TX_EN_IRQ   = 18;
  localparam int          B_TX0_EN      = 16;
  localparam int          B_TX1_EN      = 15;
  localparam int          B_TX2_EN      = 14;
  localparam int          B_NET_MODE    = 13;

  // Status register layout
  localparam int          S_RX_FULL     = 0;
  localparam int          S_RX_OVR      = 1;
  localparam int          S_TX_EMPTY    = 2;
  localparam int          S_TX_UND      = 3;

  // Sticky interrupt status / mask layout, one bit per request
  localparam int          IRQ_W         = 6;
  localparam int          I_RX          = 0;
  localparam int          I_RX_EXC      = 1;
  localparam int          I_TX          = 2;
  localparam int          I_TX_EXC      = 3;
  localparam int          I_RX_LAST     = 4;
  localparam int          I_TX_LAST     = 5;

  localparam int          NUM_TX        = 3;
  localparam int          DIV_W         = 5;

endpackage : ssic_pkg

// ===== rtl/ssic_seq_clear.sv
// Two-step clear: an arm event followed by completion of a set of actions.
// Assumes i_arm and i_done are single-cycle strobes on i_clk; i_need is a level mask.
`timescale 1ns/1ns
module ssic_seq_clear #(
  parameter int WIDTH = 3
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_arm,
  input  wire logic [WIDTH-1:0] i_need,
  input  wire logic [WIDTH-1:0] i_done,
  output logic                  o_fire
);

  logic             armed_reg;
  logic [WIDTH-1:0] seen_reg;
  logic [WIDTH-1:0] seen_next;

  initial begin
    if (WIDTH < 1) $error("ssic_seq_clear: WIDTH must be at least 1");
  end

  assign seen_next = seen_reg | i_done;
  // Fires on the action that completes the set; a later arm restarts the count
  assign o_fire = armed_reg && ((seen_next & i_need) == i_need) && (i_done != '0);

  always_ff @(posedge i_clk) begin
    if (i_rst || o_fire) begin
      armed_reg <= 1'b0;
      seen_reg  <= '0;
    end else if (i_arm) begin
      armed_reg <= 1'b1;
      seen_reg  <= '0;
    end else if (armed_reg) begin
      seen_reg <= seen_next;
    end
  end

endmodule : ssic_seq_clear

// ===== rtl/ssic_tx_gate.sv
// Network-mode re-enable gate for one transmitter and its pin enable.
// Assumes word-end and frame-start strobes from the shifter on i_clk.
`timescale 1ns/1ns
module ssic_tx_gate (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_net_mode,
  input  wire logic i_en,
  input  wire logic i_word_end,
  input  wire logic i_frame_start,
  output logic      o_active,
  output logic      o_pin_oe
);

  logic en_d_reg;
  logic toggled_reg;
  logic off_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= i_en;
    end
  end

  // A clear noted during the word takes effect when that word ends
  always_ff @(posedge i_clk) begin
    if (i_rst || i_frame_start) begin
      toggled_reg <= 1'b0;
    end else if (i_net_mode && en_d_reg && !i_en) begin
      toggled_reg <= 1'b1; // see (RQ14)
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_frame_start) begin
      off_reg <= 1'b0; // see (RQ14)
    end else if (toggled_reg && i_word_end) begin
      off_reg <= 1'b1; // see (RQ14)
    end
  end

  assign o_active = i_en && !off_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pin_oe <= 1'b0;
    end else begin
      o_pin_oe <= i_en && !(off_reg || (toggled_reg && i_word_end)); // see (RQ15)
    end
  end

endmodule : ssic_tx_gate

// ===== rtl/ssic_irq_ctl.sv
// Interrupt enable, flag and request logic for one synchronous serial port.
// Assumes an APB master on i_clk and a shifter that strobes frame and slot events.
`timescale 1ns/1ns
module ssic_irq_ctl #(
  parameter int NUM_TX = ssic_pkg::NUM_TX
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sw_reset,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Shifter events
  input  wire logic        i_rx_word,
  input  wire logic [23:0] i_rx_data,
  input  wire logic        i_tx_load,
  input  wire logic        i_word_end,
  input  wire logic        i_frame_start,
  input  wire logic        i_last_slot_start,
  input  wire logic        i_last_slot_end,
  input  wire logic [4:0]  i_frame_div,
  // Requests to the interrupt controller, held as levels
  output logic             o_rx_req,
  output logic             o_rx_exc_req,
  output logic             o_tx_req,
  output logic             o_tx_exc_req,
  output logic             o_rx_last_req,
  output logic             o_tx_last_req,
  output logic             o_irq,
  output logic [2:0]       o_tx_active,
  output logic [2:0]       o_tx_pin_oe
);

  initial begin
    if (NUM_TX != ssic_pkg::NUM_TX) $error("ssic_irq_ctl: NUM_TX must be 3");
  end

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction : merge_strb

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  //////////////////////////////////////////////////////////////////////////////

  typedef enum logic [1:0] {
    SSIC_IDLE   = 2'b01,
    SSIC_ANSWER = 2'b10
  } ssic_apb_e;

  ssic_apb_e   apb_reg;
  logic        access;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [23:0] ctl_reg;
  logic [23:0] ctl_next;
  logic [23:0] rx_buf_reg;
  logic [7:0]  tslot_reg;
  logic        rx_full_reg;
  logic        rx_ovr_reg;
  logic        tx_empty_reg;
  logic        tx_und_reg;
  logic [ssic_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [ssic_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [ssic_pkg::IRQ_W-1:0] events;

  // Access phase lasts two cycles: pready comes the edge after the first access cycle
  assign access = i_psel && i_penable && (apb_reg == SSIC_IDLE);
  assign wr     = access && i_pwrite;
  assign rd     = access && !i_pwrite;

  always_comb begin
    case (i_paddr)
      ssic_pkg::ADDR_CTL_B, ssic_pkg::ADDR_STATUS, ssic_pkg::ADDR_RX_DATA,
      ssic_pkg::ADDR_TX0, ssic_pkg::ADDR_TX1, ssic_pkg::ADDR_TX2,
      ssic_pkg::ADDR_TSLOT, ssic_pkg::ADDR_IRQ_STAT, ssic_pkg::ADDR_IRQ_MASK,
      ssic_pkg::ADDR_FRAME: mapped = 1'b1;
      default:              mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      apb_reg <= SSIC_IDLE;
    end else begin
      case (apb_reg)
        SSIC_IDLE:   if (access) apb_reg <= SSIC_ANSWER;
        SSIC_ANSWER: apb_reg <= SSIC_IDLE;
        default:     apb_reg <= SSIC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end else begin
      o_pready  <= access;
      o_pslverr <= access && !mapped;
      o_prdata  <= 32'h00000000;
      if (rd) begin
        case (i_paddr)
          ssic_pkg::ADDR_CTL_B:    o_prdata <= {8'h00, ctl_reg};
          ssic_pkg::ADDR_STATUS:   o_prdata <= {28'h0000000, tx_und_reg, tx_empty_reg,
                                                rx_ovr_reg, rx_full_reg};
          ssic_pkg::ADDR_RX_DATA:  o_prdata <= {8'h00, rx_buf_reg};
          ssic_pkg::ADDR_TSLOT:    o_prdata <= {24'h000000, tslot_reg};
          ssic_pkg::ADDR_IRQ_STAT: o_prdata <= {26'h0000000, irq_stat_reg};
          ssic_pkg::ADDR_IRQ_MASK: o_prdata <= {26'h0000000, irq_mask_reg};
          ssic_pkg::ADDR_FRAME:    o_prdata <= {27'h0000000, i_frame_div};
          default:                 o_prdata <= 32'h00000000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register B
  //////////////////////////////////////////////////////////////////////////////

  assign ctl_next = 24'(merge_strb({8'h00, ctl_reg}, i_pwdata, i_pstrb));

  always_ff @(posedge i_clk) begin
    if (i_rst || i_sw_reset) begin
      ctl_reg <= ssic_pkg::CTL_RESET; // see (RQ1)
    end else if (wr && i_paddr == ssic_pkg::ADDR_CTL_B) begin
      ctl_reg <= ctl_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tslot_reg <= 8'h00;
    end else if (wr && i_paddr == ssic_pkg::ADDR_TSLOT && i_pstrb[0]) begin
      tslot_reg <= i_pwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter enables and pins
  //////////////////////////////////////////////////////////////////////////////

  logic [2:0] tx_en;
  logic [2:0] tx_active;
  logic [2:0] tx_wr;

  assign tx_en = {ctl_reg[ssic_pkg::B_TX2_EN], ctl_reg[ssic_pkg::B_TX1_EN],
                  ctl_reg[ssic_pkg::B_TX0_EN]};
  assign tx_wr = {wr && i_paddr == ssic_pkg::ADDR_TX2, wr && i_paddr == ssic_pkg::ADDR_TX1,
                  wr && i_paddr == ssic_pkg::ADDR_TX0};

  for (genvar t = 0; t < 3; t++) begin : g_tx
    ssic_tx_gate u_gate (
      .i_clk         (i_clk),
      .i_rst         (i_rst),
      .i_net_mode    (ctl_reg[ssic_pkg::B_NET_MODE]),
      .i_en          (tx_en[t]),
      .i_word_end    (i_word_end),
      .i_frame_start (i_frame_start),
      .o_active      (tx_active[t]),
      .o_pin_oe      (o_tx_pin_oe[t])
    );
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tx_active <= 3'b000;
    end else begin
      o_tx_active <= tx_active;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags
  //////////////////////////////////////////////////////////////////////////////

  logic stat_rd;
  logic rx_rd;
  logic rx_ovr_clr;
  logic tx_und_clr;
  logic tx_fill;
  logic [2:0] tx_seen_reg;
  logic [2:0] tx_seen_next;

  assign stat_rd = rd && i_paddr == ssic_pkg::ADDR_STATUS;
  assign rx_rd   = rd && i_paddr == ssic_pkg::ADDR_RX_DATA;
  assign tx_seen_next = tx_seen_reg | (tx_wr & tx_en);
  // Empty clears once every enabled transmitter has been written
  assign tx_fill = ((|(tx_wr & tx_en)) && ((tx_seen_next & tx_en) == tx_en))
                   || (wr && i_paddr == ssic_pkg::ADDR_TSLOT);

  always_ff @(posedge i_clk) begin
    if (i_rst || i_tx_load || tx_fill) tx_seen_reg <= 3'b000;
    else tx_seen_reg <= tx_seen_next;
  end

  // Overrun clears on status read then receive data read
  ssic_seq_clear #(.WIDTH(1)) u_rx_clr (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_arm  (stat_rd),
    .i_need (1'b1),
    .i_done (rx_rd),
    .o_fire (rx_ovr_clr)
  );

  // Underrun clears on status read then writes to all enabled transmitters
  ssic_seq_clear #(.WIDTH(3)) u_tx_clr (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_arm  (stat_rd),
    .i_need (tx_en),
    .i_done (tx_wr & tx_en),
    .o_fire (tx_und_clr)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_full_reg <= 1'b0;
      rx_ovr_reg  <= 1'b0;
      rx_buf_reg  <= 24'h000000;
    end else begin
      if (i_rx_word) begin
        rx_buf_reg  <= i_rx_data;
        rx_full_reg <= 1'b1;
        if (rx_full_reg && !rx_rd) rx_ovr_reg <= 1'b1;
        else if (rx_ovr_clr) rx_ovr_reg <= 1'b0;
      end else begin
        if (rx_rd) rx_full_reg <= 1'b0; // see (RQ9)
        if (rx_ovr_clr) rx_ovr_reg <= 1'b0; // see (RQ3)
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_empty_reg <= 1'b1;
      tx_und_reg   <= 1'b0;
    end else begin
      // A load that finds the buffer still empty is an underrun; set beats clear
      if (i_tx_load) begin
        tx_empty_reg <= 1'b1;
        if (tx_empty_reg && !tx_fill) tx_und_reg <= 1'b1;
        else if (tx_und_clr) tx_und_reg <= 1'b0;
      end else begin
        if (tx_fill) tx_empty_reg <= 1'b0; // see (RQ12)
        if (tx_und_clr) tx_und_reg <= 1'b0; // see (RQ5)
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Requests
  //////////////////////////////////////////////////////////////////////////////

  logic on_demand;
  logic rx_exc;
  logic tx_exc;
  logic last_ok;

  assign on_demand = (i_frame_div == 5'h00);
  assign last_ok   = ctl_reg[ssic_pkg::B_NET_MODE] && !on_demand; // see (RQ8)
  assign rx_exc    = ctl_reg[ssic_pkg::B_RX_EXC_EN] && rx_full_reg && rx_ovr_reg; // see (RQ2)
  assign tx_exc    = ctl_reg[ssic_pkg::B_TX_EXC_EN] && tx_empty_reg && tx_und_reg; // see (RQ4)

  assign events[ssic_pkg::I_RX_EXC]  = rx_exc;
  assign events[ssic_pkg::I_RX]      = ctl_reg[ssic_pkg::B_RX_EN_IRQ] && rx_full_reg && !rx_exc;
  assign events[ssic_pkg::I_TX_EXC]  = tx_exc;
  assign events[ssic_pkg::I_TX]      = ctl_reg[ssic_pkg::B_TX_EN_IRQ] && tx_empty_reg && !tx_exc;
  assign events[ssic_pkg::I_RX_LAST] = last_ok && ctl_reg[ssic_pkg::B_RX_LAST_EN]
                                       && i_last_slot_end;
  assign events[ssic_pkg::I_TX_LAST] = last_ok && ctl_reg[ssic_pkg::B_TX_LAST_EN]
                                       && i_last_slot_start;

  // Levels recomputed each clock, so clearing an enable drops the request on the next clock
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rx_req     <= 1'b0;
      o_rx_exc_req <= 1'b0;
      o_tx_req     <= 1'b0;
      o_tx_exc_req <= 1'b0;
    end else begin
      o_rx_exc_req <= rx_exc; // see (RQ10)
      o_rx_req     <= events[ssic_pkg::I_RX]; // see (RQ9) (RQ10) (RQ17)
      o_tx_exc_req <= tx_exc; // see (RQ13)
      o_tx_req     <= events[ssic_pkg::I_TX]; // see (RQ11) (RQ13) (RQ17)
    end
  end

  // Last-slot requests are events, held until write-one-clear or until their enable, network mode or a nonzero frame divider goes away
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rx_last_req <= 1'b0;
      o_tx_last_req <= 1'b0;
    end else begin
      o_rx_last_req <= irq_stat_reg[ssic_pkg::I_RX_LAST] && last_ok
                       && ctl_reg[ssic_pkg::B_RX_LAST_EN]; // see (RQ6) (RQ17)
      o_tx_last_req <= irq_stat_reg[ssic_pkg::I_TX_LAST] && last_ok
                       && ctl_reg[ssic_pkg::B_TX_LAST_EN]; // see (RQ7) (RQ17)
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status, mask and summary interrupt
  //////////////////////////////////////////////////////////////////////////////

  logic [ssic_pkg::IRQ_W-1:0] w1c;

  assign w1c = (wr && i_paddr == ssic_pkg::ADDR_IRQ_STAT && i_pstrb[0]) ?
               i_pwdata[ssic_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~w1c) | events; // set wins over clear
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_mask_reg <= '0;
    end else if (wr && i_paddr == ssic_pkg::ADDR_IRQ_MASK && i_pstrb[0]) begin
      irq_mask_reg <= i_pwdata[ssic_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule : ssic_irq_ctl

// ===== bench/ssic_irq_ctl_sva.sv
// Checker for the serial port interrupt-control block.
// Assumes it is bound to ssic_irq_ctl and sees only its ports.
`timescale 1ns/1ns
module ssic_irq_ctl_sva #(
  parameter int NUM_TX = 3
) (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_sw_reset,
  input wire logic       i_psel,
  input wire logic       i_penable,
  input wire logic       i_rx_word,
  input wire logic       i_tx_load,
  input wire logic       i_frame_start,
  input wire logic       i_last_slot_start,
  input wire logic       i_last_slot_end,
  input wire logic [4:0] i_frame_div,
  input wire logic       o_pready,
  input wire logic       o_pslverr,
  input wire logic       o_rx_req,
  input wire logic       o_rx_exc_req,
  input wire logic       o_tx_req,
  input wire logic       o_tx_exc_req,
  input wire logic       o_rx_last_req,
  input wire logic       o_tx_last_req,
  input wire logic [2:0] o_tx_active,
  input wire logic [2:0] o_tx_pin_oe
);
  logic [3:0] cause_h;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Recent causes that may legally move a level; wide so pipeline depth is not pinned
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cause_h <= 4'hF;
    end else begin
      cause_h <= {cause_h[2:0], (i_psel & i_penable) | i_rx_word | i_tx_load
                  | i_sw_reset | i_frame_start};
    end
  end
  sequence s_acc;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_ans;
    o_pready ##1 !o_pready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_APB_ANSWER: assert property (s_acc |=> s_ans)
    else $error("pready not a single pulse after the access");
  AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  AST_RESET_CLEAR: assert property ($past(i_rst) |-> !o_rx_req && !o_tx_req
    && !o_rx_exc_req && !o_tx_exc_req && o_tx_active == 3'h0)
    else $error("outputs not cleared by reset");
  AST_RX_PRIO: assert property (!(o_rx_req && o_rx_exc_req))
    else $error("rx normal and exception requests together");
  AST_TX_PRIO: assert property (!(o_tx_req && o_tx_exc_req))
    else $error("tx normal and exception requests together");
  AST_REQ_HOLD: assert property ($fell(o_rx_req) || $fell(o_rx_exc_req)
    || $fell(o_tx_req) || $fell(o_tx_exc_req) |-> cause_h != 4'h0)
    else $error("request dropped without a cause");
  AST_RX_LAST: assert property ($rose(o_rx_last_req) |-> $past(i_last_slot_end, 2)
    && $past(i_frame_div, 2) != 5'h00)
    else $error("rx last-slot request without a slot end");
  AST_TX_LAST: assert property ($rose(o_tx_last_req) |-> $past(i_last_slot_start, 2)
    && $past(i_frame_div, 2) != 5'h00)
    else $error("tx last-slot request without a slot start");
  AST_PIN_HIZ: assert property ((o_tx_pin_oe & ~(o_tx_active | $past(o_tx_active)))
    == 3'h0)
    else $error("tx pin driven while transmitter off");
  AST_ACT_RISE: assert property ((o_tx_active & ~$past(o_tx_active)) != 3'h0
    |-> cause_h != 4'h0)
    else $error("transmitter enabled without a cause");
endmodule : ssic_irq_ctl_sva

bind ssic_irq_ctl ssic_irq_ctl_sva #(.NUM_TX(NUM_TX)) u_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_sw_reset(i_sw_reset), .i_psel(i_psel),
  .i_penable(i_penable), .i_rx_word(i_rx_word), .i_tx_load(i_tx_load),
  .i_frame_start(i_frame_start), .i_last_slot_start(i_last_slot_start),
  .i_last_slot_end(i_last_slot_end), .i_frame_div(i_frame_div), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_rx_req(o_rx_req), .o_rx_exc_req(o_rx_exc_req),
  .o_tx_req(o_tx_req), .o_tx_exc_req(o_tx_exc_req), .o_rx_last_req(o_rx_last_req),
  .o_tx_last_req(o_tx_last_req), .o_tx_active(o_tx_active), .o_tx_pin_oe(o_tx_pin_oe));

// ===== bench/ssic_intc_model.sv
// Interrupt controller model: picks the highest-priority request.
// Assumes level requests on i_clk; code 0 means nothing pending.
`timescale 1ns/1ns
module ssic_intc_model (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [5:0] i_req,
  output logic     [2:0] o_vec
);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_vec <= 3'h0;
    end else if (i_req[1]) begin
      o_vec <= 3'h1;
    end else if (i_req[0]) begin
      o_vec <= 3'h2;
    end else if (i_req[3]) begin
      o_vec <= 3'h3;
    end else if (i_req[2]) begin
      o_vec <= 3'h4;
    end else begin
      o_vec <= (i_req[4]) ? 3'h5 : ((i_req[5]) ? 3'h6 : 3'h0);
    end
  end
endmodule : ssic_intc_model

// ===== bench/testbench.sv
// Self-checking bench for the interrupt-control block with an APB master.
// Assumes the design package and the controller model are compiled first.
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic i_clk = 0, i_rst = 1, i_sw_reset = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata;
  logic [23:0] rxd = 24'h0;
  logic [4:0]  fdiv = 5'h00;
  logic [5:0]  ev = 6'h00, rq;
  logic [2:0]  act, oe, vec;
  logic        o_pready, o_pslverr, o_irq;
  logic [33:0] exp_q[$], e_m;
  int          n_errors = 0, check_count = 0, seed = 21493;
  always #5 i_clk = ~i_clk;
  ssic_irq_ctl u_ssic_irq_ctl (.i_clk(i_clk), .i_rst(i_rst), .i_sw_reset(i_sw_reset),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(4'hF), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_rx_word(ev[0]), .i_rx_data(rxd), .i_tx_load(ev[1]),
    .i_word_end(ev[2]), .i_frame_start(ev[3]), .i_last_slot_start(ev[4]),
    .i_last_slot_end(ev[5]), .i_frame_div(fdiv), .o_rx_req(rq[0]), .o_rx_exc_req(rq[1]),
    .o_tx_req(rq[2]), .o_tx_exc_req(rq[3]), .o_rx_last_req(rq[4]), .o_tx_last_req(rq[5]),
    .o_irq(o_irq), .o_tx_active(act), .o_tx_pin_oe(oe));
  ssic_intc_model u_ssic_intc_model (.i_clk(i_clk), .i_rst(i_rst), .i_req(rq), .o_vec(vec));
  ////////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  // Read expectation: bit 33 ignore, bit 32 slave error, then the word
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    int k;
    k = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      $display("Error apb wait exceeded");
      results();
    end else begin
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_clk);
    end
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
    cyc(2);
  endtask : wr
  task rd(input logic [7:0] a, input logic [33:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask : rd
  task pls(input int b);
    ev[b] <= 1'b1;
    @(posedge i_clk);
    ev[b] <= 1'b0;
    cyc(3);
  endtask : pls
  task tend(input string s);
    $display("test %s done", s);
  endtask : tend
  always @(posedge i_clk) begin
    if (o_pready === 1'b1 && i_psel === 1'b1 && i_pwrite === 1'b0 && exp_q.size() > 0) begin
      e_m = exp_q.pop_front();
      if (e_m[33] !== 1'b1) begin
        `CHK("prdata", e_m[31:0], o_prdata)
        `CHK("pslverr", e_m[32], o_pslverr)
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(12);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rd(ssic_pkg::ADDR_CTL_B, 34'h0);
    rd(8'hFC, 34'h100000000);
    tend("reset");
    rxd <= 24'($random(seed));
    wr(ssic_pkg::ADDR_CTL_B, 32'h00080000);
    pls(0);
    `CHK("rx_req", 1'b1, rq[0])
    `CHK("vec", 3'h2, vec)
    rd(ssic_pkg::ADDR_RX_DATA, {10'h000, rxd});
    cyc(2);
    `CHK("rx_req", 1'b0, rq[0])
    pls(0);
    pls(0);
    `CHK("rx_exc", 1'b0, rq[1])
    wr(ssic_pkg::ADDR_CTL_B, 32'h00880000);
    `CHK("rx_exc", 1'b1, rq[1])
    `CHK("rx_req", 1'b0, rq[0])
    `CHK("vec", 3'h1, vec)
    rd(ssic_pkg::ADDR_STATUS, 34'h000000007);
    rd(ssic_pkg::ADDR_RX_DATA, {10'h000, rxd});
    cyc(2);
    `CHK("rx_exc", 1'b0, rq[1])
    rd(ssic_pkg::ADDR_STATUS, 34'h000000004);
    tend("receive");
    wr(ssic_pkg::ADDR_CTL_B, 32'h00050000);
    `CHK("tx_req", 1'b1, rq[2])
    rd(ssic_pkg::ADDR_STATUS, 34'h000000004);
    wr(ssic_pkg::ADDR_CTL_B, 32'h00010000);
    `CHK("tx_req", 1'b0, rq[2])
    wr(ssic_pkg::ADDR_CTL_B, 32'h00050000);
    wr(ssic_pkg::ADDR_TX0, 32'($random(seed)));
    `CHK("tx_req", 1'b0, rq[2])
    pls(1);
    `CHK("tx_req", 1'b1, rq[2])
    wr(ssic_pkg::ADDR_TSLOT, 32'h0);
    `CHK("tx_req", 1'b0, rq[2])
    wr(ssic_pkg::ADDR_CTL_B, 32'h00458000);
    pls(1);
    pls(1);
    `CHK("tx_exc", 1'b1, rq[3])
    `CHK("tx_req", 1'b0, rq[2])
    `CHK("vec", 3'h3, vec)
    rd(ssic_pkg::ADDR_STATUS, 34'h00000000C);
    wr(ssic_pkg::ADDR_TX0, 32'h0);
    `CHK("tx_exc", 1'b1, rq[3])
    wr(ssic_pkg::ADDR_TX1, 32'h0);
    `CHK("tx_exc", 1'b0, rq[3])
    tend("transmit");
    wr(ssic_pkg::ADDR_CTL_B, 32'h00302000);
    wr(ssic_pkg::ADDR_IRQ_MASK, 32'h30);
    pls(4);
    pls(5);
    `CHK("last", 2'b00, rq[5:4])
    fdiv <= 5'($unsigned($random(seed)) % 31) + 5'h01;
    pls(4);
    pls(5);
    `CHK("last", 2'b11, rq[5:4])
    `CHK("irq", 1'b1, o_irq)
    wr(ssic_pkg::ADDR_IRQ_MASK, 32'h0);
    `CHK("irq", 1'b0, o_irq)
    wr(ssic_pkg::ADDR_IRQ_STAT, 32'h3F);
    wr(ssic_pkg::ADDR_IRQ_MASK, 32'h30);
    `CHK("last", 2'b00, rq[5:4])
    `CHK("irq", 1'b0, o_irq)
    tend("last slot");
    wr(ssic_pkg::ADDR_CTL_B, 32'h00012000);
    pls(3);
    `CHK("active", 1'b1, act[0])
    `CHK("pin_oe", 1'b1, oe[0])
    wr(ssic_pkg::ADDR_CTL_B, 32'h00002000);
    wr(ssic_pkg::ADDR_CTL_B, 32'h00012000);
    pls(2);
    `CHK("active", 1'b0, act[0])
    `CHK("pin_oe", 1'b0, oe[0])
    pls(3);
    `CHK("active", 1'b1, act[0])
    tend("network");
    i_sw_reset <= 1'b1;
    @(posedge i_clk);
    i_sw_reset <= 1'b0;
    rd(ssic_pkg::ADDR_CTL_B, 34'h0);
    cyc(2);
    tend("soft reset");
    results();
  end
endmodule : testbench
